// ---- ise_exec.sv ----
// Purpose: Executes the increment-and-skip-if-zero and increment-and-skip-if-nonzero instructions
// Assumes: Data memory returns read data the clock after the one in which its read strobe is high
// Notes:   Registers over APB with zero wait states; the unit keeps no arithmetic status flags
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "ise_regs.svh"

// Summary of operation
// - The sum of the file register and one goes to the accumulator when the destination bit is 0, else to the file.
// - The skip-if-zero form discards the prefetched instruction and runs a no-operation when the sum is zero.
// - The skip-if-nonzero form discards the prefetched instruction and runs a no-operation when the sum is not zero.
// - A taken skip makes the instruction two instruction cycles long, the second a no-operation.
// - A taken skip over a two-word instruction costs three instruction cycles, the last two of them no-operations.
// - With the bank bit 0 and extended mode on, file operands up to 95 are indexed literal offsets.
// - With the bank bit 0 and no literal offset, the operand lies in the access bank.
// - With the bank bit 1, the bank select register chooses the general purpose register bank.
module ise_exec (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        next_two_word,
  input  wire logic [11:0] index_base,
  output logic             instr_ready,
  output logic      [11:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic      [7:0]  accum,
  output logic             discard_next,
  output logic             nop_active,
  output logic             instr_done
);

  // Opcode match, used by decode and by the skip decision
  function automatic logic is_op(input logic [5:0] opc, input logic [5:0] ref_opc);
    is_op = (opc == ref_opc);
  endfunction : is_op

  ise_pkg::ise_state_type   state_q, state_d;
  ise_pkg::ise_instr_type   instr_q, instr_d;
  ise_pkg::ise_instr_type   instr_in;
  ise_pkg::ise_mem_req_type req_q, req_d;
  logic                     ext_q, ext_d;
  logic [3:0]               bank_q, bank_d;
  logic [7:0]               accum_q, accum_d;
  logic [7:0]               result_q, result_d;
  logic                     skip_q, skip_d;
  logic                     ill_q, ill_d;
  logic                     two_q, two_d;
  logic [3:0]               cnt_q, cnt_d;
  logic                     disc_q, disc_d;
  logic                     done_q, done_d;
  logic [31:0]              rdata_q, rdata_d;
  logic                     err_q, err_d;
  logic [11:0]              addr_formed;
  logic [7:0]               sum;
  logic                     apb_wr;
  logic                     apb_rd;
  logic                     take;
  logic                     known;

  assign instr_in = instr_word;
  assign sum      = 8'(mem_rdata + 8'h01);
  assign apb_wr   = psel && penable && pwrite;
  assign apb_rd   = psel && !penable && !pwrite;
  assign take     = instr_valid && instr_ready;
  assign known    = is_op(instr_in.opcode, `ISE_OPC_INC_SZ) || is_op(instr_in.opcode, `ISE_OPC_INC_SNZ);

  // Operand address from the word on the instruction port
  ise_addr_unit u_addr (
    .file       (instr_in.file),
    .bank       (instr_in.bank),
    .ext_en     (ext_q),
    .bank_sel   (bank_q),
    .index_base (index_base),
    .addr       (addr_formed)
  );

  // Handshake outputs are combinational, data outputs from flops
  assign instr_ready  = (state_q == ise_pkg::ISE_IDLE);
  assign nop_active   = (state_q == ise_pkg::ISE_NOP);
  assign pready       = 1'b1;
  assign prdata       = rdata_q;
  assign pslverr      = err_q;
  assign mem_addr     = req_q.addr;
  assign mem_rd       = req_q.rd;
  assign mem_wr       = req_q.wr;
  assign mem_wdata    = req_q.wdata;
  assign accum        = accum_q;
  assign discard_next = disc_q;
  assign instr_done   = done_q;

  // Sequencer: one execute instruction cycle, then zero, one or two no-operation cycles
  always_comb begin
    state_d  = state_q;
    instr_d  = instr_q;
    req_d    = req_q;
    result_d = result_q;
    skip_d   = skip_q;
    two_d    = two_q;
    cnt_d    = cnt_q;
    disc_d   = 1'b0;
    done_d   = 1'b0;
    accum_d  = accum_q;
    req_d.rd = 1'b0;
    req_d.wr = 1'b0;
    // Software preset of the accumulator; an executing write below overrides it
    if (apb_wr && (paddr == `ISE_OFS_ACCUM)) begin
      accum_d = pwdata[7:0];
    end
    case (state_q)
      ise_pkg::ISE_IDLE: begin
        if (take && known) begin
          instr_d    = instr_in;
          two_d      = next_two_word;
          req_d.addr = addr_formed;
          req_d.rd   = 1'b1;
          state_d    = ise_pkg::ISE_READ;
        end
      end
      ise_pkg::ISE_READ: begin
        state_d = ise_pkg::ISE_WRITE;
      end
      ise_pkg::ISE_WRITE: begin
        // Keep the sum so STATUS can still report it once the instruction is over
        result_d = sum;
        if (instr_q.dest) begin
          req_d.wr    = 1'b1;
          req_d.wdata = sum;
        end else begin
          accum_d = sum;
        end
        if (is_op(instr_q.opcode, `ISE_OPC_INC_SZ)) begin
          skip_d = (sum == 8'h00);
        end else begin
          skip_d = (sum != 8'h00);
        end
        if (skip_d) begin
          disc_d  = 1'b1;
          // One NOP cycle, or two when the skipped word pair must be dropped
          cnt_d   = two_q ? 4'(`ISE_CLKS_PER_ICYC * 2 - 1) : 4'(`ISE_CLKS_PER_ICYC - 1);
          state_d = ise_pkg::ISE_NOP;
        end else begin
          state_d = ise_pkg::ISE_DONE;
        end
      end
      ise_pkg::ISE_NOP: begin
        if (cnt_q == 4'h0) begin
          state_d = ise_pkg::ISE_DONE;
        end else begin
          cnt_d = 4'(cnt_q - 4'h1);
        end
      end
      ise_pkg::ISE_DONE: begin
        done_d  = 1'b1;
        state_d = ise_pkg::ISE_IDLE;
      end
      default: begin
        state_d = ise_pkg::ISE_IDLE;
      end
    endcase
  end

  // Register file next values; a set of the illegal flag wins over its clear
  always_comb begin
    ext_d   = ext_q;
    bank_d  = bank_q;
    ill_d   = ill_q;
    err_d   = 1'b0;
    rdata_d = rdata_q;
    if (apb_wr) begin
      case (paddr)
        `ISE_OFS_CTRL:   ext_d  = pwdata[`ISE_CTRL_EXT_BIT];
        `ISE_OFS_BANK:   bank_d = pwdata[3:0];
        `ISE_OFS_STATUS: if (pwdata[`ISE_STAT_ILL_BIT]) ill_d = 1'b0;
        `ISE_OFS_ACCUM:  ;
        default:         ;
      endcase
    end
    if (take && !known) begin
      ill_d = 1'b1;
    end
    // Read data is latched in setup so it stands through the access phase
    if (apb_rd) begin
      rdata_d = 32'h00000000;
      case (paddr)
        `ISE_OFS_CTRL:   rdata_d[`ISE_CTRL_EXT_BIT] = ext_q;
        `ISE_OFS_BANK:   rdata_d[3:0] = bank_q;
        `ISE_OFS_STATUS: begin
          rdata_d[7:0]               = result_q;
          rdata_d[`ISE_STAT_SKIP_BIT] = skip_q;
          rdata_d[`ISE_STAT_BUSY_BIT] = (state_q != ise_pkg::ISE_IDLE);
          rdata_d[`ISE_STAT_ILL_BIT]  = ill_q;
        end
        `ISE_OFS_ACCUM:  rdata_d[7:0] = accum_q;
        default:         rdata_d = 32'h00000000;
      endcase
    end
    // Unmapped address answers with an error in the access phase
    if (psel && !penable) begin
      err_d = !((paddr == `ISE_OFS_CTRL) || (paddr == `ISE_OFS_BANK) ||
                (paddr == `ISE_OFS_STATUS) || (paddr == `ISE_OFS_ACCUM));
    end
  end

  // All state registered here, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q  <= ise_pkg::ISE_IDLE;
      instr_q  <= '0;
      req_q    <= '0;
      ext_q    <= `ISE_CTRL_RST;
      bank_q   <= `ISE_BANK_RST;
      accum_q  <= `ISE_ACCUM_RST;
      result_q <= `ISE_RESULT_RST;
      skip_q   <= 1'b0;
      ill_q    <= 1'b0;
      two_q    <= 1'b0;
      cnt_q    <= 4'h0;
      disc_q   <= 1'b0;
      done_q   <= 1'b0;
      rdata_q  <= 32'h00000000;
      err_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      instr_q  <= instr_d;
      req_q    <= req_d;
      ext_q    <= ext_d;
      bank_q   <= bank_d;
      accum_q  <= accum_d;
      result_q <= result_d;
      skip_q   <= skip_d;
      ill_q    <= ill_d;
      two_q    <= two_d;
      cnt_q    <= cnt_d;
      disc_q   <= disc_d;
      done_q   <= done_d;
      rdata_q  <= rdata_d;
      err_q    <= err_d;
    end
  end

  // The unit has no status flag outputs at all, so flags stay untouched by construction

endmodule : ise_exec

// ---- ise_regs.svh ----
// Purpose: Register offsets, field positions, reset values and timing counts of the increment-skip unit
// Assumes: Included by its bare name from the main module, the address unit and the bench
// Notes:   Definitions only
`ifndef ISE_REGS_SVH
`define ISE_REGS_SVH

// Register byte offsets on the APB
`define ISE_OFS_CTRL       12'h000
`define ISE_OFS_BANK       12'h004
`define ISE_OFS_STATUS     12'h008
`define ISE_OFS_ACCUM      12'h00C

// Field positions
`define ISE_CTRL_EXT_BIT   0
`define ISE_STAT_SKIP_BIT  8
`define ISE_STAT_BUSY_BIT  9
`define ISE_STAT_ILL_BIT   10

// Reset values
`define ISE_CTRL_RST       1'h0
`define ISE_BANK_RST       4'h0
`define ISE_ACCUM_RST      8'h00
`define ISE_RESULT_RST     8'h00

// Opcode upper six bits
`define ISE_OPC_INC_SZ     6'h0F
`define ISE_OPC_INC_SNZ    6'h12

// Addressing
`define ISE_ILO_MAX        8'h5F
`define ISE_ACC_LO_TOP     8'h5F
`define ISE_ACC_HI_BANK    4'hF

// One instruction cycle lasts this many clocks
`define ISE_CLKS_PER_ICYC  4'h3

`endif

// ---- ise_pkg.sv ----
// Purpose: Types shared by the increment-skip unit
// Assumes: Constants live in ise_regs.svh
// Notes:   Nothing here is imported; users write ise_pkg::name
package ise_pkg;

  // Fields of one program word
  typedef struct packed {
    logic [5:0] opcode;
    logic       dest;
    logic       bank;
    logic [7:0] file;
  } ise_instr_type;

  // Data memory request
  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } ise_mem_req_type;

  typedef enum logic [2:0] {
    ISE_IDLE,
    ISE_READ,
    ISE_WRITE,
    ISE_NOP,
    ISE_DONE
  } ise_state_type;

endpackage : ise_pkg

// ---- ise_addr_unit.sv ----
// Purpose: Forms the data memory address of a byte-oriented file operand
// Assumes: Index base comes from the core on the same clock
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "ise_regs.svh"

module ise_addr_unit (
  input  wire logic [7:0]  file,
  input  wire logic        bank,
  input  wire logic        ext_en,
  input  wire logic [3:0]  bank_sel,
  input  wire logic [11:0] index_base,
  output logic      [11:0] addr
);

  // Literal offset first, then access bank, then banked register
  always_comb begin
    if (!bank && ext_en && (file <= `ISE_ILO_MAX)) begin
      addr = 12'(index_base + {4'h0, file});
    end else if (!bank) begin
      if (file <= `ISE_ACC_LO_TOP) begin
        addr = {4'h0, file};
      end else begin
        addr = {`ISE_ACC_HI_BANK, file};
      end
    end else begin
      addr = {bank_sel, file};
    end
  end

endmodule : ise_addr_unit

// ---- ise_exec_sva.sv ----
// Purpose: Port-level checker for the increment-skip unit
// Assumes: Memory answers one clock after mem_rd
// Notes:   Bound to ise_exec from the bench top file
`timescale 1ns/1ps

module ise_exec_sva (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        next_two_word,
  input wire logic        instr_ready,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  input wire logic [7:0]  accum,
  input wire logic        discard_next,
  input wire logic        nop_active,
  input wire logic        instr_done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Accepted word with a known opcode; unknown ones are flagged only
  wire logic acc = instr_valid && instr_ready && (instr_word[15:10] == 6'h0F || instr_word[15:10] == 6'h12);
  wire logic op_z = instr_word[15:10] == 6'h0F;

  property p_read;
    acc |=> mem_rd && !instr_ready;
  endproperty
  a_read: assert property (p_read) else $error("operand read missing");
  property p_noskip;
    acc ##3 !discard_next |=> instr_done;
  endproperty
  a_noskip: assert property (p_noskip) else $error("plain finish late");
  property p_skip2;
    (acc && !next_two_word) ##3 discard_next |-> nop_active[*3] ##1 !nop_active ##1 instr_done;
  endproperty
  a_skip2: assert property (p_skip2) else $error("one-word skip length wrong");
  property p_skip3;
    (acc && next_two_word) ##3 discard_next |-> nop_active[*6] ##1 !nop_active ##1 instr_done;
  endproperty
  a_skip3: assert property (p_skip3) else $error("two-word skip length wrong");
  property p_zero;
    (acc && op_z) ##3 1'b1 |-> discard_next == ($past(mem_rdata) == 8'hFF);
  endproperty
  a_zero: assert property (p_zero) else $error("zero skip decision wrong");
  property p_nzero;
    (acc && !op_z) ##3 1'b1 |-> discard_next == ($past(mem_rdata) != 8'hFF);
  endproperty
  a_nzero: assert property (p_nzero) else $error("nonzero skip decision wrong");
  property p_wback;
    (acc && instr_word[9]) |-> ##3 mem_wr && mem_wdata == $past(mem_rdata) + 8'h01;
  endproperty
  a_wback: assert property (p_wback) else $error("file write back wrong");
  property p_waccum;
    (acc && !instr_word[9]) |-> ##3 !mem_wr ##1 accum == $past(mem_rdata, 2) + 8'h01;
  endproperty
  a_waccum: assert property (p_waccum) else $error("accumulator result wrong");
  property p_bank;
    acc && instr_word[8] |=> mem_addr[7:0] == $past(instr_word[7:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_access;
    acc && !instr_word[8] && instr_word[7:0] > 8'h5F |=> mem_addr == {4'hF, $past(instr_word[7:0])};
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");

  // Main scenarios reached
  c_skip: cover property (discard_next);
  c_wr: cover property (mem_wr);
  c_long: cover property (nop_active[*6]);
endmodule : ise_exec_sva

// ---- increment_skip_exec_tb.sv ----
// Purpose: Self-checking bench for the increment-skip unit
// Assumes: Zero-wait APB; bench memory answers one clock after mem_rd
// Notes:   Random operands from a fixed seed, files 5F and 60 forced as corners
`timescale 1ns/1ps
`include "ise_regs.svh"

module increment_skip_exec_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n, psel, penable, pwrite, pready, pslverr, instr_valid, next_two_word;
  logic        instr_ready, mem_rd, mem_wr, discard_next, nop_active, instr_done, err, ext, two, skip;
  logic [11:0] paddr, index_base, mem_addr, a;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] instr_word, w;
  logic [7:0]  mem_wdata, d, sum;
  logic [7:0]  mem_rdata = 8'h00;
  logic [7:0]  mem [4096];
  logic [3:0]  bk;
  logic [31:0] nops, disc;
  int          n_mismatch, n_compared, lat;
  int          cyc = 0;

  ise_exec u_dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instr_valid, .instr_word, .next_two_word, .index_base, .instr_ready, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .accum(), .discard_next, .nop_active, .instr_done);

  initial forever #2 clk_sys = ~clk_sys;

  // Memory; between reads the data line toggles so a stale sample is caught
  always @(posedge clk_sys) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, ad, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // Offer one word, then count cycles, no-operation cycles and discards up to done
  task automatic issue(input logic [15:0] wd, input logic tw);
    @(posedge clk_sys);
    {instr_valid, instr_word, next_two_word} <= {1'b1, wd, tw};
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    nops = 0;
    disc = 0;
    for (lat = 1; lat < 40; lat++) begin
      #1;
      nops += nop_active;
      disc += discard_next;
      if (instr_done === 1'b1) break;
      @(posedge clk_sys);
    end
  endtask : issue

  function automatic logic [11:0] exp_addr(input logic [15:0] x, input logic e, input logic [3:0] b,
                                           input logic [11:0] ib);
    if (x[8]) return {b, x[7:0]};
    if (x[7:0] > `ISE_ILO_MAX) return {4'hF, x[7:0]};
    return e ? ib + 12'(x[7:0]) : {4'h0, x[7:0]};
  endfunction : exp_addr

  task automatic results();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, instr_valid, instr_word} = '0;
    {next_two_word, index_base, n_mismatch, n_compared} = '0;
    void'($urandom(32'hB96D));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Every register starts at zero
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk(32'(err), 32'h1);
    apb(1'b1, `ISE_OFS_ACCUM, 32'h5A);
    apb(1'b0, `ISE_OFS_ACCUM, 32'h0);
    chk(rd, 32'h5A);
    // Unknown opcode is flagged and never skips
    issue(16'h0000, 1'b1);
    chk(32'(disc), 32'h0);
    apb(1'b0, `ISE_OFS_STATUS, 32'h0);
    chk(32'(rd[10]), 32'h1);
    // Writing one to the sticky bit clears it
    apb(1'b1, `ISE_OFS_STATUS, 32'h00000400);
    apb(1'b0, `ISE_OFS_STATUS, 32'h0);
    chk(32'(rd[10]), 32'h0);
    for (int i = 0; i < 32; i++) begin
      w = {i[0] ? `ISE_OPC_INC_SNZ : `ISE_OPC_INC_SZ, 10'($urandom)};
      w[7:0] = (i % 4 == 0) ? 8'h5F : (i % 4 == 1) ? 8'h60 : w[7:0];
      d = (i % 3 == 0) ? 8'hFF : 8'($urandom);
      {ext, two, bk} = {i[2], 1'($urandom), 4'($urandom)};
      index_base <= 12'($urandom);
      apb(1'b1, `ISE_OFS_CTRL, 32'(ext));
      apb(1'b1, `ISE_OFS_BANK, 32'(bk));
      a = exp_addr(w, ext, bk, index_base);
      mem[a] = d;
      sum = d + 8'h01;
      skip = (w[15:10] == `ISE_OPC_INC_SZ) == (sum == 8'h00);
      issue(w, two);
      chk(lat, skip ? (two ? 10 : 7) : 4);
      chk(nops, skip ? (two ? 6 : 3) : 0);
      chk(32'(disc), 32'(skip));
      apb(1'b0, w[9] ? `ISE_OFS_STATUS : `ISE_OFS_ACCUM, 32'h0);
      chk(w[9] ? 32'(mem[a]) : rd, 32'(sum));
      if (w[9]) chk(32'(rd[8:0]), {23'h0, skip, sum});
    end
    results();
  end
endmodule : increment_skip_exec_tb

bind ise_exec ise_exec_sva u_sva (.clk_sys, .rst_n, .instr_valid, .instr_word, .next_two_word, .instr_ready,
  .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .accum, .discard_next, .nop_active, .instr_done);
